// ---- core/dac_cfg_pkg.sv ----
// Constants for the DAC format, attenuation mode and output phase configuration registers
package dac_cfg_pkg;
   // Control word layout
   localparam int          WORD_W          = 16;
   localparam int          IDX_HI          = 14;
   localparam int          IDX_LO          = 8;
   localparam int          IDX_W           = 7;
   localparam int          DATA_W          = 8;
   // Register indices
   localparam logic [6:0]  IDX_FMT_FILTER  = 7'h14;
   localparam logic [6:0]  IDX_ATTEN_MODE  = 7'h15;
   localparam logic [6:0]  IDX_PHASE_ZERO  = 7'h16;
   // Field positions
   localparam int          FMT_LO          = 0;
   localparam int          FMT_W           = 3;
   localparam int          ROLLOFF_BIT     = 5;
   localparam int          RANGE_BIT       = 0;
   localparam int          INVERT_BIT      = 0;
   localparam int          ZPOL_BIT        = 1;
   localparam int          ZROUTE_BIT      = 2;
   // Reset values
   localparam logic [2:0]  FMT_DEFAULT     = 3'h5;
   localparam logic        ROLLOFF_DEFAULT = 1'b0;
   localparam logic        RANGE_DEFAULT   = 1'b0;
   localparam logic        INVERT_DEFAULT  = 1'b0;
   localparam logic        ZPOL_DEFAULT    = 1'b0;
   localparam logic        ZROUTE_DEFAULT  = 1'b0;
   // Format encodings
   localparam logic [2:0]  FMT_RJ24        = 3'h0;
   localparam logic [2:0]  FMT_RJ20        = 3'h1;
   localparam logic [2:0]  FMT_RJ18        = 3'h2;
   localparam logic [2:0]  FMT_RJ16        = 3'h3;
   localparam logic [2:0]  FMT_I2S         = 3'h4;
   localparam logic [2:0]  FMT_LJ          = 3'h5;
   // Attenuator
   localparam int          ATTEN_W         = 8;
   localparam logic [7:0]  ATTEN_MAX       = 8'hff;
   localparam logic [7:0]  MUTE_FINE_TOP   = 8'h80;
   localparam logic [7:0]  MUTE_WIDE_TOP   = 8'h9a;
   localparam int          STEP_PERIODS    = 8;
   localparam logic [2:0]  STEP_LAST       = 3'(STEP_PERIODS - 1);
   // Soft reset hold, in system clocks
   localparam int          SOFT_RESET_CMD_CYCLES     = 1024;
   localparam logic [10:0] SOFT_RESET_CMD_LOAD       = 11'(SOFT_RESET_CMD_CYCLES);
   localparam logic [10:0] SOFT_RESET_CMD_ONE        = 11'h1;
endpackage : dac_cfg_pkg

// ---- core/dac_format_output_config_regs.sv ----
// Format, attenuation mode and output phase/zero-flag configuration of a stereo DAC
// Behaviour
// RQ1 - The three-bit format field selects RJ 24/20/18/16-bit, I2S, left-justified or reserved.
// RQ2 - After reset the format field holds 101, the left-justified 16 to 24 bit format.
// RQ3 - Bit 5 of register 20 picks sharp (0, default) or slow (1) filter rolloff.
// RQ4 - Bit 0 of register 21 picks 0.5 dB steps to -63 dB (0, default) or 1 dB steps to -100 dB.
// RQ5 - Bit 0 of register 22 leaves the output phase normal (0) or inverts it (1).
// RQ6 - Bit 1 of register 22 makes zero flags high on zero detect (0) or low (1).
// RQ7 - Bit 2 of register 22 gives separate L/R flags (0) or one combined flag on the right pin (1).
// RQ8 - The host sends bit 15 clear, the index in bits 14..8, data in 7..0, reserved bits zero.
// RQ9 - Register 22 bit 3 is fixed zero and bits 7..4 are reserved, with no function.
// RQ10 - The attenuator moves one step toward its target once every 8 sampling periods.
// RQ11 - Attenuation is step times (code - 255); codes to 128 fine or 154 wide are full mute.
// RQ12 - A soft reset holds the block in reset for 1024 clocks and restores all defaults.
// RQ13 - Other indices leave these registers alone; a write lands only after the whole word.
`timescale 1ns/1ps
module dac_format_output_config_regs
   import dac_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Received control word, one-cycle strobe after the last bit
   input  wire logic                word_valid,
   input  wire logic [WORD_W-1:0]   word_data,
   // Soft reset request, one-cycle pulse
   input  wire logic                soft_reset_cmd,
   // Sampling-rate pulse and programmed attenuation per channel
   input  wire logic                fs_tick,
   input  wire logic [ATTEN_W-1:0]  target_atten_l,
   input  wire logic [ATTEN_W-1:0]  target_atten_r,
   // Raw zero detect per channel, high on zero
   input  wire logic                left_zero_det,
   input  wire logic                right_zero_det,
   // Configuration outputs
   output logic [FMT_W-1:0]         audio_format_sel,
   output logic                     rolloff_sel,
   output logic                     atten_range_sel,
   output logic                     output_invert,
   output logic                     zero_flag_polarity,
   output logic                     zero_flag_routing,
   // Zero-flag pins
   output logic                     left_zero_flag,
   output logic                     right_zero_flag,
   // Attenuator state
   output logic [ATTEN_W-1:0]       channel_atten_level_l,
   output logic [ATTEN_W-1:0]       channel_atten_level_r,
   output logic                     mute_l,
   output logic                     mute_r,
   // Soft reset in progress
   output logic                     reset_active
);

   // Full mute decision for a level in the given range
   function automatic logic is_muted(input logic [ATTEN_W-1:0] lvl, input logic wide);
      is_muted = wide ? (lvl <= MUTE_WIDE_TOP) : (lvl <= MUTE_FINE_TOP);
   endfunction : is_muted

   logic [10:0]          soft_reset_cmd_cnt_reg;
   logic [10:0]          soft_reset_cmd_cnt_next;
   logic [2:0]           step_cnt_reg;
   logic [ATTEN_W-1:0]   level_reg [2];
   logic [ATTEN_W-1:0]   level_next [2];
   logic [ATTEN_W-1:0]   target [2];
   logic                 mute_reg [2];

   // Word decode
   wire  [IDX_W-1:0]     word_index = word_data[IDX_HI:IDX_LO];
   wire                  in_soft_reset_cmd    = soft_reset_cmd || (soft_reset_cmd_cnt_reg != '0);
   wire                  wr_ok      = word_valid && !in_soft_reset_cmd;
   wire                  wr_fmt     = wr_ok && (word_index == IDX_FMT_FILTER);   // RQ13
   wire                  wr_range   = wr_ok && (word_index == IDX_ATTEN_MODE);   // RQ13
   wire                  wr_phase   = wr_ok && (word_index == IDX_PHASE_ZERO);   // RQ13
   wire                  step_en    = fs_tick && (step_cnt_reg == STEP_LAST);    // RQ10

   // Soft reset hold counter
   assign soft_reset_cmd_cnt_next = soft_reset_cmd ? SOFT_RESET_CMD_LOAD :
                          (soft_reset_cmd_cnt_reg != '0) ? soft_reset_cmd_cnt_reg - SOFT_RESET_CMD_ONE : soft_reset_cmd_cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_reset_cmd_cnt_reg <= '0;
         reset_active <= 1'b0;
      end else begin
         soft_reset_cmd_cnt_reg <= soft_reset_cmd_cnt_next;                  // RQ12
         reset_active <= (soft_reset_cmd_cnt_next != '0);
      end
   end

   // Register 20: format and rolloff
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         audio_format_sel <= FMT_DEFAULT;                // RQ2
         rolloff_sel      <= ROLLOFF_DEFAULT;
      end else if (in_soft_reset_cmd) begin
         audio_format_sel <= FMT_DEFAULT;                // RQ12
         rolloff_sel      <= ROLLOFF_DEFAULT;
      end else if (wr_fmt) begin
         audio_format_sel <= word_data[FMT_LO +: FMT_W]; // RQ1
         rolloff_sel      <= word_data[ROLLOFF_BIT];     // RQ3
      end
   end

   // Register 21: attenuation range
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         atten_range_sel <= RANGE_DEFAULT;
      end else if (in_soft_reset_cmd) begin
         atten_range_sel <= RANGE_DEFAULT;
      end else if (wr_range) begin
         atten_range_sel <= word_data[RANGE_BIT];        // RQ4
      end
   end

   // Register 22: phase and zero flags; bits 7..3 are not stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         output_invert      <= INVERT_DEFAULT;
         zero_flag_polarity <= ZPOL_DEFAULT;
         zero_flag_routing  <= ZROUTE_DEFAULT;
      end else if (in_soft_reset_cmd) begin
         output_invert      <= INVERT_DEFAULT;
         zero_flag_polarity <= ZPOL_DEFAULT;
         zero_flag_routing  <= ZROUTE_DEFAULT;
      end else if (wr_phase) begin
         output_invert      <= word_data[INVERT_BIT];    // RQ5
         zero_flag_polarity <= word_data[ZPOL_BIT];      // RQ6
         zero_flag_routing  <= word_data[ZROUTE_BIT];    // RQ7 RQ9
      end
   end

   // Zero-flag pins; unassigned left pin sits low in combined mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left_zero_flag  <= 1'b0;
         right_zero_flag <= 1'b0;
      end else begin
         left_zero_flag  <= zero_flag_routing ? 1'b0 : (left_zero_det ^ zero_flag_polarity);
         right_zero_flag <= (zero_flag_routing ? (left_zero_det && right_zero_det)
                                                : right_zero_det) ^ zero_flag_polarity;
      end
   end

   // Divider of sampling periods between attenuator steps
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt_reg <= '0;
      end else if (in_soft_reset_cmd) begin
         step_cnt_reg <= '0;
      end else if (fs_tick) begin
         step_cnt_reg <= step_cnt_reg + 3'h1;            // RQ10
      end
   end

   assign target[0] = target_atten_l;
   assign target[1] = target_atten_r;

   // Per-channel attenuator stepping toward the programmed level
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      assign level_next[ch] = !step_en ? level_reg[ch] :
                              (level_reg[ch] < target[ch]) ? level_reg[ch] + 8'h01 :
                              (level_reg[ch] > target[ch]) ? level_reg[ch] - 8'h01 :
                              level_reg[ch];            // RQ10

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            level_reg[ch] <= ATTEN_MAX;
            mute_reg[ch]  <= 1'b0;
         end else if (in_soft_reset_cmd) begin
            level_reg[ch] <= ATTEN_MAX;
            mute_reg[ch]  <= 1'b0;
         end else begin
            level_reg[ch] <= level_next[ch];
            mute_reg[ch]  <= is_muted(level_next[ch], atten_range_sel); // RQ11
         end
      end
   end

   assign channel_atten_level_l = level_reg[0];
   assign channel_atten_level_r = level_reg[1];
   assign mute_l                = mute_reg[0];
   assign mute_r                = mute_reg[1];

   // Checks on the register writes, zero flags, attenuator stepping, mute and soft reset
   fmt_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
      wr_fmt && !soft_reset_cmd |=> audio_format_sel == $past(word_data[2:0]))
      else $error("format field not loaded");
   fmt_default_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      soft_reset_cmd |=> (audio_format_sel == FMT_LJ) [*8])
      else $error("format not at left-justified default");
   rolloff_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
      wr_fmt |=> rolloff_sel == $past(word_data[5]))
      else $error("rolloff bit not loaded");
   range_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
      wr_range |=> atten_range_sel == $past(word_data[0]))
      else $error("range bit not loaded");
   phase_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
      wr_phase |=> output_invert == $past(word_data[0]) && !reset_active)
      else $error("phase bit not loaded");
   zero_polarity_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
      !zero_flag_routing ##1 1 |-> left_zero_flag == ($past(left_zero_det) ^ $past(zero_flag_polarity)))
      else $error("left zero flag polarity wrong");
   zero_combined_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
      zero_flag_routing ##1 1 |-> right_zero_flag ==
         (($past(left_zero_det) && $past(right_zero_det)) ^ $past(zero_flag_polarity))
         && !left_zero_flag)
      else $error("combined zero flag wrong");
   step_pace_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
      !step_en && !in_soft_reset_cmd |=> $stable(channel_atten_level_l) && $stable(channel_atten_level_r))
      else $error("attenuator moved off its step pulse");
   mute_level_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
      !in_soft_reset_cmd |=> mute_l == is_muted(channel_atten_level_l, $past(atten_range_sel)))
      else $error("mute does not match level");
   soft_reset_cmd_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
      soft_reset_cmd |=> reset_active && channel_atten_level_l == ATTEN_MAX)
      else $error("soft reset did not start the hold");

   // Checker-side count of cycles the hold flag stays up, restarted by each command
   logic [10:0]          hold_cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_reg <= '0;
      end else if (soft_reset_cmd || !reset_active) begin
         hold_cnt_reg <= '0;
      end else begin
         hold_cnt_reg <= hold_cnt_reg + SOFT_RESET_CMD_ONE;
      end
   end

   soft_reset_cmd_length_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
      $fell(reset_active) |-> hold_cnt_reg == SOFT_RESET_CMD_LOAD)
      else $error("soft reset hold length wrong");
   other_index_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
      word_valid && !wr_fmt && !wr_range && !wr_phase && !in_soft_reset_cmd
         |=> $stable(audio_format_sel) && $stable(atten_range_sel) && $stable(output_invert))
      else $error("foreign index changed a register");

endmodule : dac_format_output_config_regs

// ---- verification/ctrl_host_model.sv ----
// Host controller model that forms and sends control words
`timescale 1ns/1ps
module ctrl_host_model
   import dac_cfg_pkg::*;
(
   // Clock
   input  wire logic          clk,
   // Control word towards the block
   output logic               word_valid,
   output logic [WORD_W-1:0]  word_data
);
   initial begin
      word_valid = 1'b0;
      word_data  = 16'h0;
   end

   // One word as a one-cycle strobe; released data shows its inverse
   task automatic send(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data);
      word_data  = {1'b0, idx, data};
      word_valid = 1'b1;
      @(negedge clk);
      word_valid = 1'b0;
      word_data  = ~word_data;
      @(negedge clk);
   endtask : send
endmodule : ctrl_host_model

// ---- verification/dac_format_output_config_regs_tb.sv ----
// Self-checking bench for the format, attenuation mode and phase registers
`timescale 1ns/1ps
module dac_format_output_config_regs_tb;
   import dac_cfg_pkg::*;
   typedef struct packed {logic [6:0] idx; logic [7:0] data; logic [7:0] cfg;} row_t;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              soft_reset_cmd = 1'b0;
   logic              fs_tick = 1'b0;
   logic [7:0]        target_atten_l = 8'hff;
   logic [7:0]        target_atten_r = 8'hff;
   logic              left_zero_det = 1'b0;
   logic              right_zero_det = 1'b0;
   logic              word_valid;
   logic [15:0]       word_data;
   logic [2:0]        fmt;
   logic              roll, range, inv, zpol, zroute, zl, zr, mute_l, mute_r, reset_active;
   logic [7:0]        lvl_l, lvl_r;
   wire  logic [7:0]  cfg = {fmt, roll, range, inv, zpol, zroute};
   int                n_mismatch = 0;
   int                checked = 0;
   int                cycles = 0;
   // Written index and data beside the packed configuration they leave behind
   row_t              rows [14] = '{'{7'h14, 8'h00, 8'h00}, '{7'h14, 8'h21, 8'h30},
      '{7'h14, 8'h02, 8'h40}, '{7'h14, 8'h23, 8'h70}, '{7'h14, 8'h04, 8'h80},
      '{7'h14, 8'h26, 8'hd0}, '{7'h14, 8'h07, 8'he0},
      '{7'h14, 8'h05, 8'ha0}, '{7'h15, 8'h01, 8'ha8}, '{7'h16, 8'h01, 8'hac},
      '{7'h16, 8'h06, 8'hab}, '{7'h13, 8'h07, 8'hab}, '{7'h15, 8'h00, 8'ha3},
      '{7'h16, 8'h00, 8'ha0}};

   dac_format_output_config_regs uut (.clk(clk), .rst_n(rst_n), .word_valid(word_valid),
      .word_data(word_data), .soft_reset_cmd(soft_reset_cmd), .fs_tick(fs_tick),
      .target_atten_l(target_atten_l), .target_atten_r(target_atten_r),
      .left_zero_det(left_zero_det), .right_zero_det(right_zero_det),
      .audio_format_sel(fmt), .rolloff_sel(roll), .atten_range_sel(range),
      .output_invert(inv), .zero_flag_polarity(zpol), .zero_flag_routing(zroute),
      .left_zero_flag(zl), .right_zero_flag(zr), .channel_atten_level_l(lvl_l),
      .channel_atten_level_r(lvl_r), .mute_l(mute_l), .mute_r(mute_r),
      .reset_active(reset_active));

   ctrl_host_model host (.clk(clk), .word_valid(word_valid), .word_data(word_data));

   // Clock and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // Programs the phase register, applies zero detects, compares {left, right} flags
   task automatic zf(input logic [7:0] r22, input logic dl, input logic dr, input logic [1:0] e);
      host.send(IDX_PHASE_ZERO, r22);
      left_zero_det = dl;
      right_zero_det = dr;
      repeat (2) @(negedge clk);
      chk8({6'h0, zl, zr}, {6'h0, e});
   endtask : zf

   task automatic tick;
      fs_tick = 1'b1;
      @(negedge clk);
      fs_tick = 1'b0;
      @(negedge clk);
   endtask : tick

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk8(cfg, 8'ha0);
      chk8(lvl_l, 8'hff);
      $display("test reset done");
      foreach (rows[i]) begin
         host.send(rows[i].idx, rows[i].data);
         chk8(cfg, rows[i].cfg);
      end
      $display("test table done");
      zf(8'h00, 1'b1, 1'b0, 2'b10);
      zf(8'h00, 1'b0, 1'b1, 2'b01);
      zf(8'h02, 1'b1, 1'b0, 2'b01);
      zf(8'h04, 1'b1, 1'b1, 2'b01);
      zf(8'h04, 1'b1, 1'b0, 2'b00);
      zf(8'h06, 1'b0, 1'b0, 2'b01);
      $display("test zero flags done");
      // Soft reset: defaults return, a write early in the hold is refused, hold length checked
      host.send(IDX_FMT_FILTER, 8'h23);
      soft_reset_cmd = 1'b1;
      @(negedge clk);
      soft_reset_cmd = 1'b0;
      chk8({7'h0, reset_active}, 8'h01);
      host.send(IDX_FMT_FILTER, 8'h00);
      chk8(cfg, 8'ha0);
      repeat (1021) @(negedge clk);
      chk8({7'h0, reset_active}, 8'h01);
      @(negedge clk);
      chk8({7'h0, reset_active}, 8'h00);
      host.send(IDX_FMT_FILTER, 8'h21);
      chk8(cfg, 8'h30);
      $display("test soft reset done");
      // Attenuator steps once per eight sampling ticks
      target_atten_l = 8'hfd;
      repeat (7) tick();
      chk8(lvl_l, 8'hff);
      tick();
      chk8(lvl_l, 8'hfe);
      chk8({lvl_r[6:0], mute_l}, 8'hfe);
      $display("test attenuator done");
      // Mute edges in wide mode, then the same level in fine mode
      host.send(IDX_ATTEN_MODE, 8'h01);
      target_atten_l = 8'h9a;
      target_atten_r = 8'h9b;
      repeat (800) tick();
      chk8(lvl_l, 8'h9a);
      chk8(lvl_r, 8'h9b);
      chk8({6'h0, mute_l, mute_r}, 8'h02);
      host.send(IDX_ATTEN_MODE, 8'h00);
      chk8({6'h0, mute_l, mute_r}, 8'h00);
      $display("test mute done");
      // Asynchronous reset in mid-run, then a word on the first edge after release
      rst_n = 1'b0;
      @(negedge clk);
      chk8(cfg, 8'ha0);
      chk8(lvl_r, 8'hff);
      chk8({6'h0, mute_l, mute_r}, 8'h00);
      rst_n = 1'b1;
      host.send(IDX_FMT_FILTER, 8'h21);
      chk8(cfg, 8'h30);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule : dac_format_output_config_regs_tb
